// file: dv/signal_peak_monitor_chk.sv
// Checker on the monitor link carrier, watching its signals only.
// Assumes one clock and a link sample every DECIM cycles.
`default_nettype none

module signal_peak_monitor_chk #(
    parameter int DECIM = 4  // System cycles per link sample.
) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        linkValid,
    input wire logic [15:0] linkWord,
    input wire logic [1:0]  ctrlCount,
    input wire logic [1:0]  monitorSlot
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic [1:0] monPos;   // Word bit holding the monitor bit.
    logic       monBit;   // Monitor bit of the present word.
    logic [4:0] hist_ff;  // Last five monitor bits, newest lowest.

    // Slots count down from the top control bit.
    assign monPos = (ctrlCount == 2'h3 ? 2'h2 : 2'h1) - monitorSlot;
    assign monBit = linkWord[monPos];

    // History restarts as all ones while no slot carries monitor data.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset)
            hist_ff <= 5'h1f;
        else if (monitorSlot == 2'h3)
            hist_ff <= 5'h1f;
        else if (linkValid)
            hist_ff <= {hist_ff[3:0], monBit};
    end

    AST_LINK_PULSE: assert property (linkValid |=> !linkValid)
        else $error("link strobe longer than one cycle");
    AST_LINK_CADENCE: assert property (linkValid |-> ##DECIM linkValid)
        else $error("link strobe cadence wrong");
    AST_WORD_HOLD: assert property ($changed(linkWord) |-> linkValid)
        else $error("link word changed without strobe");
    AST_SLOT_RANGE: assert property (monitorSlot != 2'h3 |-> monitorSlot < ctrlCount)
        else $error("monitor slot beyond control bits");
    AST_TAIL_ZERO: assert property (linkValid && ctrlCount == 2'h0 |-> linkWord[1:0] == 2'h0)
        else $error("tail bits not zero");
    AST_ONE_SLOT_MSB: assert property (linkValid && ctrlCount == 2'h1 |-> !linkWord[0])
        else $error("single control bit not in top slot");
    AST_FRAME_START: assert property (linkValid && monitorSlot != 2'h3 && hist_ff == 5'h10 |-> monBit)
        else $error("frame start bit missing");
    AST_SUBFRAME_STRIDE: assert property (linkValid && monitorSlot != 2'h3 && hist_ff[3:0] == 4'h0 |-> monBit)
        else $error("subframe start bit missing");
endmodule

`default_nettype wire

// file: dv/signal_peak_monitor_test.sv
// Bench for the peak monitor and link receiver joined by the carrier.
// Assumes the map header, package and carrier compile first.
`include "signal_peak_monitor_map.svh"
`default_nettype none

module signal_peak_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic               sys_clk;         // System clock.
    logic               reset;           // Active high reset.
    logic signed [13:0] sampleIn;        // Converter sample.
    logic [11:0]        regAddr;         // Register address.
    logic [7:0]         regWrData;       // Register write data.
    logic               regWr;           // Write strobe.
    logic               regRd;           // Read strobe.
    logic [7:0]         regRdData;       // Register read data.
    logic [12:0]        peakOut;         // Peak rebuilt from the link.
    logic               peakValid;       // Rebuilt peak strobe.
    logic               locked;          // Receiver frame lock.
    logic [7:0]         cnt;             // Frame counter before refresh.
    logic [7:0]         b0, b1, b2;      // Read bytes.
    int                 num_errors = 0;  // Mismatches.
    int                 cmp_count = 0;   // Comparisons.
    int                 cycles = 0;      // Elapsed cycles.
    logic signed [13:0] smp [4] = '{-14'sd1000, 14'sd4000, -14'sd8192, 14'sd5};
    logic [12:0]        pk [4] = '{13'd1000, 13'd4000, 13'd8191, 13'd5};

    monitor_link_if monitor_link_if_i ();
    signal_peak_monitor #(.DECIM(4)) signal_peak_monitor_i (
        .sys_clk(sys_clk), .reset(reset), .sampleIn(sampleIn),
        .overrangeIn(1'b0), .timingEventIn(1'b0), .fastDetectIn(1'b0),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .link(monitor_link_if_i));
    monitor_link_receiver monitor_link_receiver_i (
        .sys_clk(sys_clk), .reset(reset), .link(monitor_link_if_i),
        .peakOut(peakOut), .peakValid(peakValid), .locked(locked),
        .alignError());
    signal_peak_monitor_chk #(.DECIM(4)) signal_peak_monitor_chk_i (
        .sys_clk(sys_clk), .reset(reset),
        .linkValid(monitor_link_if_i.linkValid),
        .linkWord(monitor_link_if_i.linkWord),
        .ctrlCount(monitor_link_if_i.ctrlCount),
        .monitorSlot(monitor_link_if_i.monitorSlot));

    // Free running clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Cuts a hang short well past the expected run length.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("Checks: %0d, errors: %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [19:0] exp,
                       input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle.
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        d = regRdData;
    endtask

    // Refreshes the result, checks counter, result bytes and link peak.
    task automatic measure(input logic [12:0] exp);
        rd(`SPM_FRAME_COUNTER, cnt);
        wr(`SPM_RESULT_REFRESH, 8'h10);
        rd(`SPM_FRAME_COUNTER, b0);
        chk("frame_counter", {12'h0, cnt + 8'h1}, {12'h0, b0});
        rd(`SPM_PEAK_RESULT_LOW, b0);
        rd(`SPM_PEAK_RESULT_MID, b1);
        rd(`SPM_PEAK_RESULT_HIGH, b2);
        chk("result", {exp, 7'h0}, {b2[3:0], b1, b0});
        for (int n = 0; n < 600 && !(peakValid === 1'b1 && peakOut === exp); n++)
            @(posedge sys_clk);
        chk("link_peak", {7'h0, exp}, {7'h0, peakOut});
        chk("link_lock", 20'h1, {19'h0, locked});
    endtask

    // Main sequence.
    initial begin
        reset = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 12'h0;
        regWrData = 8'h0;
        sampleIn = 14'sd0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`SPM_PERIOD_LOW, b0);
        chk("period_low", 20'h50, {12'h0, b0});
        rd(12'h300, b0);
        chk("unmapped", 20'h0, {12'h0, b0});
        wr(`SPM_PERIOD_LOW, 8'h08);
        wr(`SPM_CTRL_BIT_COUNT, 8'h01);
        wr(`SPM_SLOT_SELECT_A, 8'h03);
        wr(`SPM_EMBED_CONTROL_A, 8'h03);
        wr(`SPM_EMBED_CONTROL_B, 8'h02);
        wr(`SPM_MONITOR_CONTROL, 8'h02);
        // Sign, clipping, rise and fall of the peak across periods.
        for (int i = 0; i < 4; i++) begin
            sampleIn <= smp[i];
            repeat (80) @(posedge sys_clk);
            measure(pk[i]);
        end
        // Detection off: the held value stays.
        wr(`SPM_MONITOR_CONTROL, 8'h00);
        sampleIn <= 14'sd100;
        repeat (80) @(posedge sys_clk);
        measure(13'd5);
        conclude();
    end
endmodule

`default_nettype wire

// file: rtl/monitor_link_if.sv
// Carrier between the monitor transmitter and the link receiver logic.
// Assumes both ends share the one system clock.
`default_nettype none

interface monitor_link_if;
    logic        linkValid;   // One-cycle strobe per link sample.
    logic [15:0] linkWord;    // Sample word with control bits.
    logic [1:0]  ctrlCount;   // Number of control bits per sample.
    logic [1:0]  monitorSlot; // Control slot with monitor data, 3 = none.

    // Transmitting end.
    modport device (
        output linkValid,
        output linkWord,
        output ctrlCount,
        output monitorSlot
    );

    // Receiving end.
    modport receiver (
        input linkValid,
        input linkWord,
        input ctrlCount,
        input monitorSlot
    );
endinterface

`default_nettype wire

// file: rtl/monitor_link_receiver.sv
// Link receiver end: pulls the monitor bit out of each link sample and
// rebuilds the peak value. Assumes the transmitter on the same clock.
`include "signal_peak_monitor_map.svh"
`default_nettype none

module monitor_link_receiver (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    monitor_link_if.receiver             link,
    output logic [`SPM_PEAK_W-1:0]       peakOut,
    output logic                         peakValid,
    output logic                         locked,
    output logic                         alignError
);

    // Frame shift register, alignment state and bit counter.
    logic [`SPM_FRAME_W-1:0]              shift_ff;
    logic [`SPM_FRAME_W-1:0]              nxt_shift;
    signal_peak_monitor_pkg::rx_state_type state_ff;
    logic [4:0]                           bitCnt_ff;
    logic [`SPM_PEAK_W-1:0]               peak_ff;
    logic                                 peakValid_ff;
    logic                                 alignError_ff;
    logic                                 monBit;
    logic [1:0]                           topPos;
    logic                                 startsOk;
    logic                                 takeBit;
    logic [`SPM_RESULT_W-1:0]             payload;

    // Top control position is bit 1, or bit 2 when three bits are carried.
    assign topPos  = (link.ctrlCount == 2'h3) ? 2'h2 : 2'h1;
    // A sample carries a monitor bit only when a valid slot is named.
    assign takeBit = link.linkValid && (link.monitorSlot != 2'h3)
                     && (link.monitorSlot < link.ctrlCount);
    // Extract the monitor control bit from its slot.
    assign monBit  = link.linkWord[2'(topPos - link.monitorSlot)];
    assign nxt_shift = {shift_ff[`SPM_FRAME_W-2:0], monBit};

    // The five start bits sit at the first position of each subframe, and
    // the zero tail after the last peak bit pins the frame boundary; start
    // bits alone also match windows shifted by whole subframes.
    assign startsOk = nxt_shift[24] & nxt_shift[19] & nxt_shift[14]
                      & nxt_shift[9] & nxt_shift[4]
                      & (payload[6:0] == 7'h00);
    // Strip the start bits back out of the frame.
    assign payload = {nxt_shift[23:20], nxt_shift[18:15], nxt_shift[13:10],
                      nxt_shift[8:5], nxt_shift[3:0]};

    // Shift in monitor bits, most significant first.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shift_ff <= 25'h0000000;
        end else if (takeBit) begin
            shift_ff <= nxt_shift;
        end
    end

    // Alignment: search for a full start pattern, then check every frame.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_ff      <= signal_peak_monitor_pkg::RX_SEARCH;
            bitCnt_ff     <= 5'h00;
            peak_ff       <= 13'h0000;
            peakValid_ff  <= 1'b0;
            alignError_ff <= 1'b0;
        end else begin
            peakValid_ff  <= 1'b0;
            alignError_ff <= 1'b0;
            if (takeBit) begin
                case (state_ff)
                    signal_peak_monitor_pkg::RX_SEARCH: begin
                        // First window whose start bits all match and whose tail is zero.
                        if (startsOk) begin
                            state_ff     <= signal_peak_monitor_pkg::RX_LOCKED;
                            bitCnt_ff    <= 5'h00;
                            peak_ff      <= payload[19:7];
                            peakValid_ff <= 1'b1;
                        end
                    end
                    signal_peak_monitor_pkg::RX_LOCKED: begin
                        if (bitCnt_ff == 5'(`SPM_FRAME_W - 1)) begin
                            bitCnt_ff <= 5'h00;
                            if (startsOk) begin
                                peak_ff      <= payload[19:7];
                                peakValid_ff <= 1'b1;
                            end else begin
                                // A bad start bit drops the lock.
                                state_ff      <= signal_peak_monitor_pkg::RX_SEARCH;
                                alignError_ff <= 1'b1;
                            end
                        end else begin
                            bitCnt_ff <= bitCnt_ff + 5'h01;
                        end
                    end
                    default: begin
                        state_ff <= signal_peak_monitor_pkg::RX_SEARCH;
                    end
                endcase
            end
        end
    end

    assign peakOut    = peak_ff;
    assign peakValid  = peakValid_ff;
    assign alignError = alignError_ff;
    assign locked     = (state_ff == signal_peak_monitor_pkg::RX_LOCKED);

endmodule

`default_nettype wire

// file: rtl/signal_peak_monitor.sv
// Peak magnitude monitor: measures the largest sample magnitude per period,
// offers it over the register port and as a serial frame in link samples.
// Assumes samples and register strobes come from logic on sys_clk.
//
// What this block does
// - Track sample magnitude only, sign ignored.
// - Peak is 13 bits; period is 24 bits.
// - Detection runs only while control bit 1 set.
// - Software programs period before enabling detection.
// - Enable loads timer; decrements each decimated sample.
// - Keep larger of magnitude and running maximum.
// - Seed running maximum with present sample magnitude.
// - At count one, copy maximum into holding register.
// - After transfer, reload timer and reseed maximum.
// - Refresh bit updates result and frame counter.
// - Software polls frame counter until it changes.
// - Result is 20-bit word, peak in top bits.
// - Embedding needs 0x279 bits 1:0 and 0x27A bit 1.
// - Up to three control bits, filled from MSB.
// - Slot selection set through two configuration registers.
// - Serial frame 25 bits, five 5-bit subframes, MSB first.
// - Receiver extracts monitor bit and rebuilds peak.
// - Spare bits may carry overrange, timing, fast detect.
`include "signal_peak_monitor_map.svh"
`default_nettype none

module signal_peak_monitor #(
    parameter int DECIM = `SPM_DECIM_DEFAULT  // System cycles per sample.
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire logic signed [13:0]      sampleIn,
    input  wire logic                    overrangeIn,
    input  wire logic                    timingEventIn,
    input  wire logic                    fastDetectIn,
    input  wire logic [11:0]             regAddr,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic [7:0]                   regRdData,
    monitor_link_if.device               link
);

    // Refuse a decimation the divider cannot count.
    if (DECIM < 1 || DECIM > 256) begin : g_bad_decim
        $error("DECIM must lie between 1 and 256.");
    end

    // Divider state and the one-cycle sample strobe.
    logic [7:0]                    divCnt_ff;
    logic                          sampleStb;
    // Software registers.
    logic [7:0]                    control_ff;
    logic [`SPM_PERIOD_W-1:0]      period_ff;
    logic [7:0]                    refresh_ff;
    logic [7:0]                    embedA_ff;
    logic [7:0]                    embedB_ff;
    logic [7:0]                    slotA_ff;
    logic [7:0]                    slotB_ff;
    logic [7:0]                    ctrlCnt_ff;
    logic [7:0]                    rdData_ff;
    // Measurement state.
    logic                          active_ff;
    logic                          reseed_ff;
    logic [`SPM_PERIOD_W-1:0]      timer_ff;
    logic [`SPM_PEAK_W-1:0]        runMax_ff;
    logic [`SPM_PEAK_W-1:0]        hold_ff;
    logic [`SPM_RESULT_W-1:0]      result_ff;
    logic [7:0]                    frameCnt_ff;
    // Serial frame state.
    logic [`SPM_FRAME_W-1:0]       frame_ff;
    logic [4:0]                    frameBit_ff;
    // Link outputs.
    logic [15:0]                   linkWord_ff;
    logic                          linkValid_ff;
    // Combinational helpers.
    logic [13:0]                   magWide;
    logic [`SPM_PEAK_W-1:0]        mag;
    logic [`SPM_PEAK_W-1:0]        larger;
    logic [`SPM_PERIOD_W-1:0]      reloadVal;
    logic                          peakEnable;
    logic                          embedOn;
    logic [1:0]                    ctrlCount;
    logic [1:0]                    topPos;
    logic [2:0]                    ctrlBits;
    logic [1:0]                    monitorSlot;
    logic [15:0]                   nxt_linkWord;
    logic                          wrHit;

    // Divider: one strobe per decimated sample.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            divCnt_ff <= 8'h00;
        end else if (divCnt_ff == 8'(DECIM - 1)) begin
            divCnt_ff <= 8'h00;
        end else begin
            divCnt_ff <= divCnt_ff + 8'h01;
        end
    end
    assign sampleStb = (divCnt_ff == 8'(DECIM - 1));

    // Magnitude, sign dropped and clipped to the 13-bit peak range.
    assign magWide = sampleIn[13] ? 14'(-sampleIn) : sampleIn;
    assign mag     = magWide[13] ? 13'h1fff : magWide[12:0];
    assign larger  = (mag > runMax_ff) ? mag : runMax_ff;
    // A zero period counts as one so the timer never wraps.
    assign reloadVal  = (period_ff == 24'h000000) ? 24'h000001 : period_ff;
    assign peakEnable = control_ff[`SPM_PEAK_ENABLE_BIT];
    assign wrHit      = regWr;

    // Register writes; each register is its own byte.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            control_ff <= `SPM_REG_RESET;
            period_ff  <= `SPM_PERIOD_RESET;
            refresh_ff <= `SPM_REG_RESET;
            embedA_ff  <= `SPM_REG_RESET;
            embedB_ff  <= `SPM_REG_RESET;
            slotA_ff   <= `SPM_REG_RESET;
            slotB_ff   <= `SPM_REG_RESET;
            ctrlCnt_ff <= `SPM_REG_RESET;
        end else if (wrHit) begin
            case (regAddr)
                `SPM_MONITOR_CONTROL: control_ff <= regWrData;
                // Period lands in storage only; the timer reads it at reload.
                `SPM_PERIOD_LOW:  period_ff[7:0]   <= regWrData;
                `SPM_PERIOD_MID:  period_ff[15:8]  <= regWrData;
                `SPM_PERIOD_HIGH: period_ff[23:16] <= regWrData;
                // The refresh bit is a strobe and never stored.
                `SPM_RESULT_REFRESH: refresh_ff <= regWrData & 8'hef;
                `SPM_EMBED_CONTROL_A: embedA_ff <= regWrData;
                `SPM_EMBED_CONTROL_B: embedB_ff <= regWrData;
                `SPM_SLOT_SELECT_A:   slotA_ff  <= regWrData;
                `SPM_SLOT_SELECT_B:   slotB_ff  <= regWrData;
                `SPM_CTRL_BIT_COUNT:  ctrlCnt_ff <= regWrData;
                default: begin
                    // Writes elsewhere are ignored.
                end
            endcase
        end
    end

    // Period timer and running maximum.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            active_ff <= 1'b0;
            reseed_ff <= 1'b0;
            timer_ff  <= 24'h000000;
            runMax_ff <= 13'h0000;
            hold_ff   <= 13'h0000;
        end else if (!peakEnable) begin
            // Clearing the enable stops and rearms the measurement.
            active_ff <= 1'b0;
        end else if (!active_ff) begin
            // Start: load the timer, seed with the present sample.
            active_ff <= 1'b1;
            reseed_ff <= 1'b0;
            timer_ff  <= reloadVal;
            runMax_ff <= mag;
        end else if (sampleStb) begin
            if (timer_ff == 24'h000001) begin
                hold_ff   <= reseed_ff ? mag : larger;
                timer_ff  <= reloadVal;
                reseed_ff <= 1'b1;
            end else begin
                timer_ff  <= timer_ff - 24'h000001;
                runMax_ff <= reseed_ff ? mag : larger;
                reseed_ff <= 1'b0;
            end
        end
    end

    // Refresh strobe: copy held peak, MSB aligned, and bump the counter.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            result_ff   <= 20'h00000;
            frameCnt_ff <= 8'h00;
        end else if (wrHit && regAddr == `SPM_RESULT_REFRESH
                     && regWrData[`SPM_REFRESH_BIT]) begin
            result_ff   <= {hold_ff, 7'h00};
            frameCnt_ff <= frameCnt_ff + 8'h01;
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdData_ff <= 8'h00;
        end else if (!regRd) begin
            rdData_ff <= 8'h00;
        end else begin
            case (regAddr)
                `SPM_MONITOR_CONTROL:  rdData_ff <= control_ff;
                `SPM_PERIOD_LOW:       rdData_ff <= period_ff[7:0];
                `SPM_PERIOD_MID:       rdData_ff <= period_ff[15:8];
                `SPM_PERIOD_HIGH:      rdData_ff <= period_ff[23:16];
                `SPM_RESULT_REFRESH:   rdData_ff <= refresh_ff;
                `SPM_PEAK_RESULT_LOW:  rdData_ff <= result_ff[7:0];
                `SPM_PEAK_RESULT_MID:  rdData_ff <= result_ff[15:8];
                `SPM_PEAK_RESULT_HIGH: rdData_ff <= {4'h0, result_ff[19:16]};
                `SPM_FRAME_COUNTER:    rdData_ff <= frameCnt_ff;
                `SPM_EMBED_CONTROL_A:  rdData_ff <= embedA_ff;
                `SPM_EMBED_CONTROL_B:  rdData_ff <= embedB_ff;
                `SPM_SLOT_SELECT_A:    rdData_ff <= slotA_ff;
                `SPM_SLOT_SELECT_B:    rdData_ff <= slotB_ff;
                `SPM_CTRL_BIT_COUNT:   rdData_ff <= ctrlCnt_ff;
                default:               rdData_ff <= 8'h00;
            endcase
        end
    end
    assign regRdData = rdData_ff;

    // Embedding needs both enable fields at once.
    assign embedOn   = (embedA_ff[1:0] == 2'b11)
                       && embedB_ff[`SPM_EMBED_B_BIT];
    assign ctrlCount = ctrlCnt_ff[1:0];
    // Control field top: bit 1, or bit 2 when three bits are used.
    assign topPos    = (ctrlCount == 2'h3) ? 2'h2 : 2'h1;

    // Serial frame: five subframes of start bit then four data bits.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            frame_ff    <= 25'h0000000;
            frameBit_ff <= 5'h00;
        end else if (sampleStb) begin
            if (frameBit_ff == 5'h00) begin
                // Load the newest held peak for the next frame.
                frame_ff <= {1'b1, hold_ff[12:9], 1'b1, hold_ff[8:5],
                             1'b1, hold_ff[4:1], 1'b1, hold_ff[0], 3'h0,
                             1'b1, 4'h0};
                frameBit_ff <= 5'(`SPM_FRAME_W - 1);
            end else begin
                frame_ff    <= {frame_ff[23:0], 1'b0};
                frameBit_ff <= frameBit_ff - 5'h01;
            end
        end
    end

    // Per-slot control bit source; slot 0 is the most significant.
    for (genvar k = 0; k < 3; k++) begin : g_slot
        signal_peak_monitor_pkg::ctrl_fn_type fn;
        assign fn = signal_peak_monitor_pkg::ctrl_fn_type'(
                    (k == 0) ? slotA_ff[1:0] :
                    (k == 1) ? slotA_ff[5:4] : slotB_ff[1:0]);
        assign ctrlBits[k] =
            (fn == signal_peak_monitor_pkg::CTRL_OVERRANGE) ? overrangeIn :
            (fn == signal_peak_monitor_pkg::CTRL_TIMING) ? timingEventIn :
            (fn == signal_peak_monitor_pkg::CTRL_FASTDET) ? fastDetectIn :
            (embedOn && frameBit_ff != 5'h00 ? frame_ff[24] : 1'b0);
    end

    // Lowest used slot selected for the monitor, or 3 when none or embedding is off.
    always_comb begin
        monitorSlot = 2'h3;
        for (int k = 2; k >= 0; k--) begin
            if (k < int'(ctrlCount) && g_slot[0].fn ==
                signal_peak_monitor_pkg::CTRL_MONITOR && k == 0) begin
                monitorSlot = 2'h0;
            end
        end
        if (slotA_ff[5:4] == 2'b11 && ctrlCount > 2'h1
            && monitorSlot == 2'h3) begin
            monitorSlot = 2'h1;
        end
        if (slotB_ff[1:0] == 2'b11 && ctrlCount > 2'h2
            && monitorSlot == 2'h3) begin
            monitorSlot = 2'h2;
        end
        if (!embedOn) begin
            monitorSlot = 2'h3;
        end
    end

    // Build the link word: sample on top, control bits from MSB down.
    always_comb begin
        nxt_linkWord = {sampleIn, 2'b00};
        for (int k = 0; k < 3; k++) begin
            if (k < int'(ctrlCount)) begin
                nxt_linkWord[2'(int'(topPos) - k)] = ctrlBits[k];
            end
        end
    end

    // Link sample register, one word per decimated sample.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            linkWord_ff  <= 16'h0000;
            linkValid_ff <= 1'b0;
        end else begin
            linkValid_ff <= sampleStb;
            if (sampleStb) begin
                linkWord_ff <= nxt_linkWord;
            end
        end
    end

    assign link.linkValid   = linkValid_ff;
    assign link.linkWord    = linkWord_ff;
    assign link.ctrlCount   = ctrlCount;
    assign link.monitorSlot = monitorSlot;

endmodule

`default_nettype wire

// file: rtl/signal_peak_monitor_map.svh
// Register offsets, field positions, reset values and timing counts of the
// peak monitor. Assumes a 12-bit byte address and 8-bit register data.
`ifndef SIGNAL_PEAK_MONITOR_MAP_SVH
`define SIGNAL_PEAK_MONITOR_MAP_SVH

// Register offsets.
`define SPM_MONITOR_CONTROL   12'h270
`define SPM_PERIOD_LOW        12'h271
`define SPM_PERIOD_MID        12'h272
`define SPM_PERIOD_HIGH       12'h273
`define SPM_RESULT_REFRESH    12'h274
`define SPM_PEAK_RESULT_LOW   12'h275
`define SPM_PEAK_RESULT_MID   12'h276
`define SPM_PEAK_RESULT_HIGH  12'h277
`define SPM_FRAME_COUNTER     12'h278
`define SPM_EMBED_CONTROL_A   12'h279
`define SPM_EMBED_CONTROL_B   12'h27a
`define SPM_SLOT_SELECT_A     12'h559
`define SPM_SLOT_SELECT_B     12'h55a
`define SPM_CTRL_BIT_COUNT    12'h58f

// Field positions.
`define SPM_PEAK_ENABLE_BIT   1
`define SPM_REFRESH_BIT       4
`define SPM_EMBED_B_BIT       1

// Reset values.
`define SPM_REG_RESET         8'h00
`define SPM_PERIOD_RESET      24'h000050

// Widths and frame layout.
`define SPM_PEAK_W            13
`define SPM_PERIOD_W          24
`define SPM_RESULT_W          20
`define SPM_FRAME_W           25
`define SPM_SUBFRAME_W        5
`define SPM_LINK_W            16

// Default decimation: link samples are produced every this many cycles.
`define SPM_DECIM_DEFAULT     4

`endif

// file: rtl/signal_peak_monitor_pkg.sv
// Types shared by both ends of the peak monitor link.
// Assumes the map header is compiled alongside.
`default_nettype none

package signal_peak_monitor_pkg;

    // What a control bit slot carries.
    typedef enum logic [1:0] {
        CTRL_OVERRANGE = 2'b00,
        CTRL_TIMING    = 2'b01,
        CTRL_FASTDET   = 2'b10,
        CTRL_MONITOR   = 2'b11
    } ctrl_fn_type;

    // Frame alignment state of the link receiver.
    typedef enum logic [0:0] {
        RX_SEARCH = 1'b0,
        RX_LOCKED = 1'b1
    } rx_state_type;

endpackage

`default_nettype wire
